// [src/trigger_action_dispatcher_regs.svh]
// Purpose : named constants for the trigger action dispatcher
// Assumes : included by bare name from the design file
// Notes   : apb offsets, field positions and reset values
`ifndef TRIGGER_ACTION_DISPATCHER_REGS_SVH
`define TRIGGER_ACTION_DISPATCHER_REGS_SVH
// register byte offsets
`define TAD_CTRL_OFS     12'h000
`define TAD_STATE_OFS    12'h004
// control register fields
`define TAD_OP_LSB       0
`define TAD_OP_MSB       3
`define TAD_FXMUTE_BIT   4
`define TAD_FXBYP_BIT    5
// state register fields
`define TAD_DMUTE_BIT    0
`define TAD_CMUTE_BIT    1
`define TAD_DBYP_BIT     2
`define TAD_CBYP_BIT     3
`define TAD_ALT_BIT      4
`define TAD_FRZ_BIT      5
`define TAD_REV_BIT      6
`define TAD_LEVEL_BIT    7
// reset values
`define TAD_CTRL_RST     6'h00
`define TAD_ZERO32       32'h0000_0000
`endif

// [src/trigger_action_dispatcher_pkg.sv]
// Purpose : types for the trigger action dispatcher
// Assumes : nothing
// Notes   : operation codes follow the selection list order
package trigger_action_dispatcher_pkg;
   // selectable trigger operations
   typedef enum logic [3:0] {
      OP_DELAY_MUTE    = 4'h0,
      OP_COMB_MUTE     = 4'h1,
      OP_ALL_MUTE      = 4'h2,
      OP_DELAY_BYPASS  = 4'h3,
      OP_COMB_BYPASS   = 4'h4,
      OP_ALL_BYPASS    = 4'h5,
      OP_ALT_TOGGLE    = 4'h6,
      OP_GATED_FREEZE  = 4'h7,
      OP_GATED_REVERSE = 4'h8,
      OP_CLEAR_BUFFER  = 4'h9
   } op_type;
endpackage

// [src/trigger_action_dispatcher.sv]
// Purpose : turns jack or button triggers into effect mute/bypass/freeze actions
// Assumes : trigger_jack and trigger_button are asynchronous pins
// Notes   : apb slave with a control and a state register, zero wait states
//
// Contract
// - delay mute toggles delay mute
// - comb mute toggles comb mute
// - all mute toggles both mutes
// - all mute ignored while panel muted
// - delay bypass toggles delay bypass
// - comb bypass toggles comb bypass
// - all bypass toggles both bypasses
// - all bypass ignored while panel bypassed
// - alternation mode toggles stereo alternation
// - gated freeze follows trigger level
// - gated reverse follows trigger level
// - clear pulses both memory clears
`include "trigger_action_dispatcher_regs.svh"
module trigger_action_dispatcher (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // trigger pins
   input  wire logic        trigger_jack,
   input  wire logic        trigger_button,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // effect controls
   output logic             delay_mute,
   output logic             comb_mute,
   output logic             delay_bypass,
   output logic             comb_bypass,
   output logic             stereo_alternation,
   output logic             delay_freeze,
   output logic             delay_reverse,
   output logic             comb_clear,
   output logic             delay_clear
);
   // three-stage synchronisers for both pins
   logic [2:0] jack_sync_r;
   logic [2:0] btn_sync_r;
   logic       level_r;        // filtered trigger level (jack or button)
   logic       level_nxt;
   logic       edge_w;         // rising edge of filtered level
   // control register
   logic [3:0] op_r;           // selected operation
   logic [3:0] op_nxt;
   logic       fx_mute_r;      // panel effect-enable mute
   logic       fx_mute_nxt;
   logic       fx_byp_r;       // panel effect-enable bypass
   logic       fx_byp_nxt;
   // action state
   logic       dmute_nxt;
   logic       cmute_nxt;
   logic       dbyp_nxt;
   logic       cbyp_nxt;
   logic       alt_nxt;
   logic       frz_nxt;
   logic       rev_nxt;
   logic       clr_nxt;
   // bus
   logic [31:0] prdata_nxt;
   logic        pready_nxt;
   logic        pslverr_nxt;
   logic        acc_w;         // access phase
   logic        hit_w;         // mapped address

   // synchronisers: first stage read only by second
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         jack_sync_r <= 3'h0;
         btn_sync_r  <= 3'h0;
      end else begin
         jack_sync_r <= {jack_sync_r[1:0], trigger_jack};
         btn_sync_r  <= {btn_sync_r[1:0], trigger_button};
      end
   end

   // level changes only once stages two and three agree
   always_comb begin
      level_nxt = level_r;
      if ((jack_sync_r[1] == jack_sync_r[2]) && (btn_sync_r[1] == btn_sync_r[2])) begin
         level_nxt = jack_sync_r[2] | btn_sync_r[2];
      end
   end
   assign edge_w = level_nxt & ~level_r;

   // apb decode and register writes
   assign acc_w = psel & penable;
   assign hit_w = (paddr == `TAD_CTRL_OFS) || (paddr == `TAD_STATE_OFS);
   always_comb begin
      op_nxt      = op_r;
      fx_mute_nxt = fx_mute_r;
      fx_byp_nxt  = fx_byp_r;
      prdata_nxt  = `TAD_ZERO32;
      pready_nxt  = 1'b0;
      pslverr_nxt = 1'b0;
      if (psel && !penable) begin
         // answer ready in the access cycle
         pready_nxt  = 1'b1;
         pslverr_nxt = ~hit_w;
         if (!pwrite && paddr == `TAD_CTRL_OFS) begin
            prdata_nxt[`TAD_OP_MSB:`TAD_OP_LSB] = op_r;
            prdata_nxt[`TAD_FXMUTE_BIT]         = fx_mute_r;
            prdata_nxt[`TAD_FXBYP_BIT]          = fx_byp_r;
         end else if (!pwrite && paddr == `TAD_STATE_OFS) begin
            prdata_nxt[`TAD_DMUTE_BIT] = delay_mute;
            prdata_nxt[`TAD_CMUTE_BIT] = comb_mute;
            prdata_nxt[`TAD_DBYP_BIT]  = delay_bypass;
            prdata_nxt[`TAD_CBYP_BIT]  = comb_bypass;
            prdata_nxt[`TAD_ALT_BIT]   = stereo_alternation;
            prdata_nxt[`TAD_FRZ_BIT]   = delay_freeze;
            prdata_nxt[`TAD_REV_BIT]   = delay_reverse;
            prdata_nxt[`TAD_LEVEL_BIT] = level_r;
         end
      end else if (acc_w && pready) begin
         // write takes effect at the completing edge
         if (pwrite && paddr == `TAD_CTRL_OFS) begin
            op_nxt      = pwdata[`TAD_OP_MSB:`TAD_OP_LSB];
            fx_mute_nxt = pwdata[`TAD_FXMUTE_BIT];
            fx_byp_nxt  = pwdata[`TAD_FXBYP_BIT];
         end
      end
   end

   // action dispatch: only the selected operation acts
   always_comb begin
      dmute_nxt = delay_mute;
      cmute_nxt = comb_mute;
      dbyp_nxt  = delay_bypass;
      cbyp_nxt  = comb_bypass;
      alt_nxt   = stereo_alternation;
      frz_nxt   = 1'b0;
      rev_nxt   = 1'b0;
      clr_nxt   = 1'b0;
      unique case (op_r)
         trigger_action_dispatcher_pkg::OP_DELAY_MUTE: begin
            if (edge_w) dmute_nxt = ~delay_mute;
         end
         trigger_action_dispatcher_pkg::OP_COMB_MUTE: begin
            if (edge_w) cmute_nxt = ~comb_mute;
         end
         trigger_action_dispatcher_pkg::OP_ALL_MUTE: begin
            if (edge_w && !fx_mute_r) begin
               dmute_nxt = ~delay_mute;
               cmute_nxt = ~comb_mute;
            end
         end
         trigger_action_dispatcher_pkg::OP_DELAY_BYPASS: begin
            if (edge_w) dbyp_nxt = ~delay_bypass;
         end
         trigger_action_dispatcher_pkg::OP_COMB_BYPASS: begin
            if (edge_w) cbyp_nxt = ~comb_bypass;
         end
         trigger_action_dispatcher_pkg::OP_ALL_BYPASS: begin
            if (edge_w && !fx_byp_r) begin
               dbyp_nxt = ~delay_bypass;
               cbyp_nxt = ~comb_bypass;
            end
         end
         trigger_action_dispatcher_pkg::OP_ALT_TOGGLE: begin
            if (edge_w) alt_nxt = ~stereo_alternation;
         end
         trigger_action_dispatcher_pkg::OP_GATED_FREEZE: begin
            frz_nxt = level_nxt;
         end
         trigger_action_dispatcher_pkg::OP_GATED_REVERSE: begin
            rev_nxt = level_nxt;
         end
         trigger_action_dispatcher_pkg::OP_CLEAR_BUFFER: begin
            clr_nxt = edge_w;
         end
         default: begin
            // unused codes do nothing
         end
      endcase
   end

   // registers; all states off at reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         level_r            <= 1'b0;
         op_r               <= 4'h0;
         fx_mute_r          <= 1'b0;
         fx_byp_r           <= 1'b0;
         delay_mute         <= 1'b0;
         comb_mute          <= 1'b0;
         delay_bypass       <= 1'b0;
         comb_bypass        <= 1'b0;
         stereo_alternation <= 1'b0;
         delay_freeze       <= 1'b0;
         delay_reverse      <= 1'b0;
         comb_clear         <= 1'b0;
         delay_clear        <= 1'b0;
         prdata             <= `TAD_ZERO32;
         pready             <= 1'b0;
         pslverr            <= 1'b0;
      end else begin
         level_r            <= level_nxt;
         op_r               <= op_nxt;
         fx_mute_r          <= fx_mute_nxt;
         fx_byp_r           <= fx_byp_nxt;
         delay_mute         <= dmute_nxt;
         comb_mute          <= cmute_nxt;
         delay_bypass       <= dbyp_nxt;
         comb_bypass        <= cbyp_nxt;
         stereo_alternation <= alt_nxt;
         delay_freeze       <= frz_nxt;
         delay_reverse      <= rev_nxt;
         comb_clear         <= clr_nxt;
         delay_clear        <= clr_nxt;
         prdata             <= prdata_nxt;
         pready             <= pready_nxt;
         pslverr            <= pslverr_nxt;
      end
   end

   // checks
   property p_dmute;
      @(posedge sys_clk) disable iff (!rstn)
      (edge_w && op_r == trigger_action_dispatcher_pkg::OP_DELAY_MUTE)
         |=> (delay_mute != $past(delay_mute)) && $stable(comb_mute);
   endproperty
   a_dmute: assert property (p_dmute) else $error("delay mute not toggled");

   property p_cmute;
      @(posedge sys_clk) disable iff (!rstn)
      (edge_w && op_r == trigger_action_dispatcher_pkg::OP_COMB_MUTE)
         |=> (comb_mute != $past(comb_mute)) && $stable(delay_mute);
   endproperty
   a_cmute: assert property (p_cmute) else $error("comb mute not toggled");

   property p_amute;
      @(posedge sys_clk) disable iff (!rstn)
      (edge_w && !fx_mute_r && op_r == trigger_action_dispatcher_pkg::OP_ALL_MUTE)
         |=> $changed(comb_mute) && $changed(delay_mute);
   endproperty
   a_amute: assert property (p_amute) else $error("all mute not toggled");

   property p_amute_blk;
      @(posedge sys_clk) disable iff (!rstn)
      (fx_mute_r && op_r == trigger_action_dispatcher_pkg::OP_ALL_MUTE)
         |=> $stable(comb_mute) && $stable(delay_mute);
   endproperty
   a_amute_blk: assert property (p_amute_blk) else $error("mute changed while panel muted");

   property p_dbyp;
      @(posedge sys_clk) disable iff (!rstn)
      (edge_w && op_r == trigger_action_dispatcher_pkg::OP_DELAY_BYPASS)
         |=> $changed(delay_bypass) && $stable(comb_bypass);
   endproperty
   a_dbyp: assert property (p_dbyp) else $error("delay bypass not toggled");

   property p_cbyp;
      @(posedge sys_clk) disable iff (!rstn)
      (edge_w && op_r == trigger_action_dispatcher_pkg::OP_COMB_BYPASS)
         |=> $changed(comb_bypass) && $stable(delay_bypass);
   endproperty
   a_cbyp: assert property (p_cbyp) else $error("comb bypass not toggled");

   property p_abyp;
      @(posedge sys_clk) disable iff (!rstn)
      (edge_w && op_r == trigger_action_dispatcher_pkg::OP_ALL_BYPASS)
         |=> (fx_byp_r ? $stable(comb_bypass) : $changed(comb_bypass))
             && (comb_bypass ^ delay_bypass) == $past(comb_bypass ^ delay_bypass);
   endproperty
   a_abyp: assert property (p_abyp) else $error("all bypass wrong");

   property p_alt;
      @(posedge sys_clk) disable iff (!rstn)
      $changed(stereo_alternation)
         |-> $past(op_r) == trigger_action_dispatcher_pkg::OP_ALT_TOGGLE && $past(edge_w);
   endproperty
   a_alt: assert property (p_alt) else $error("alternation toggled without trigger");

   property p_frz;
      @(posedge sys_clk) disable iff (!rstn)
      ##1 (delay_freeze == ($past(level_nxt)
         && $past(op_r) == trigger_action_dispatcher_pkg::OP_GATED_FREEZE));
   endproperty
   a_frz: assert property (p_frz) else $error("freeze not following trigger");

   // reverse equals the filtered level in the same cycle, falling edge included
   property p_rev;
      @(posedge sys_clk) disable iff (!rstn)
      (op_r == trigger_action_dispatcher_pkg::OP_GATED_REVERSE)
         |=> (delay_reverse == level_r);
   endproperty
   a_rev: assert property (p_rev) else $error("reverse not following trigger");

   property p_clr;
      @(posedge sys_clk) disable iff (!rstn)
      comb_clear |-> delay_clear ##1 !comb_clear;
   endproperty
   a_clr: assert property (p_clr) else $error("clear not a paired pulse");
endmodule // trigger_action_dispatcher

// [verification/trigger_source.sv]
// Purpose : model of the trigger jack and the panel trigger button
// Assumes : the block synchronises both pins itself
// Notes   : pins change only right after a rising edge, held long enough to be seen
module trigger_source (
   // clock
   input  wire logic sys_clk,
   // trigger pins
   output logic      trigger_jack,
   output logic      trigger_button
);
   timeunit 1ns;
   timeprecision 1ps;
   // both pins idle low from time zero
   initial begin
      trigger_jack   = 1'b0;
      trigger_button = 1'b0;
   end
   // one pin high for hi cycles, then both low for lo cycles
   task automatic press(input logic use_btn, input int hi, input int lo);
      @(posedge sys_clk);
      if (use_btn) begin
         trigger_button <= 1'b1;
      end else begin
         trigger_jack <= 1'b1;
      end
      repeat (hi) @(posedge sys_clk);
      trigger_jack   <= 1'b0;
      trigger_button <= 1'b0;
      repeat (lo) @(posedge sys_clk);
   endtask
endmodule // trigger_source

// [verification/testbench.sv]
// Purpose : self-checking bench for the trigger action dispatcher
// Assumes : zero wait state apb slave, trigger lag of a few cycles
// Notes   : expected toggle states are tracked in exp_state
`include "trigger_action_dispatcher_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // clock, reset and apb master signals
   logic        sys_clk = 1'b0;
   logic        rstn    = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000;
   // design outputs and pins
   wire  logic  trigger_jack;
   wire  logic  trigger_button;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic        delay_mute, comb_mute, delay_bypass, comb_bypass, stereo_alternation;
   logic        delay_freeze, delay_reverse, comb_clear, delay_clear;
   // bookkeeping
   int          miscompares  = 0;
   int          total_checks = 0;
   int          comb_clears  = 0;
   int          delay_clears = 0;
   logic [4:0]  exp_state    = 5'h00;
   // clock at 4 ns period
   always #2 sys_clk = ~sys_clk;
   trigger_source src (.sys_clk(sys_clk), .trigger_jack(trigger_jack),
                       .trigger_button(trigger_button));
   trigger_action_dispatcher dut (.sys_clk(sys_clk), .rstn(rstn), .trigger_jack(trigger_jack),
      .trigger_button(trigger_button), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .delay_mute(delay_mute), .comb_mute(comb_mute), .delay_bypass(delay_bypass),
      .comb_bypass(comb_bypass), .stereo_alternation(stereo_alternation),
      .delay_freeze(delay_freeze), .delay_reverse(delay_reverse),
      .comb_clear(comb_clear), .delay_clear(delay_clear));
   // count memory clear pulses over the whole run
   always @(posedge sys_clk) begin
      if (comb_clear === 1'b1) comb_clears++;
      if (delay_clear === 1'b1) delay_clears++;
   end
   // compare and report
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready is seen
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge sys_clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      // sample pready on the rising edge; no timeout here, only the watchdog ends a hang
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // select an operation, fire one trigger, compare toggled states
   task automatic toggle_op(input logic [3:0] op, input logic [1:0] panel,
                            input logic [4:0] flip, input logic use_btn);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, `TAD_CTRL_OFS, {26'h000_0000, panel, op}, rd, err);
      src.press(use_btn, 6, 8);
      exp_state = exp_state ^ flip;
      check({27'h000_0000, stereo_alternation, comb_bypass, delay_bypass, comb_mute,
             delay_mute}, {27'h000_0000, exp_state});
      apb(1'b0, `TAD_STATE_OFS, 32'h0000_0000, rd, err);
      check({27'h000_0000, rd[4:0]}, {27'h000_0000, exp_state});
   endtask
   // gated operation: output follows the held level, then drops
   task automatic gated(input logic [3:0] op, input logic frz);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, `TAD_CTRL_OFS, {28'h000_0000, op}, rd, err);
      fork
         src.press(1'b1, 12, 8);
         begin
            repeat (9) @(negedge sys_clk);
            check({30'h0000_0000, delay_freeze, delay_reverse},
                  {30'h0000_0000, frz, ~frz});
         end
      join
      check({30'h0000_0000, delay_freeze, delay_reverse}, 32'h0000_0000);
   endtask
   // unmapped access errors, state register ignores writes
   task automatic bad_access();
      logic [31:0] rd;
      logic        err;
      apb(1'b0, 12'h008, 32'h0000_0000, rd, err);
      check({31'h0000_0000, err}, 32'h0000_0001);
      check(rd, 32'h0000_0000);
      apb(1'b1, 12'h008, 32'hFFFF_FFFF, rd, err);
      check({31'h0000_0000, err}, 32'h0000_0001);
      apb(1'b0, `TAD_CTRL_OFS, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_0008);
      apb(1'b1, `TAD_STATE_OFS, 32'hFFFF_FFFF, rd, err);
      check({31'h0000_0000, err}, 32'h0000_0000);
      apb(1'b0, `TAD_STATE_OFS, 32'h0000_0000, rd, err);
      check(rd, {27'h000_0000, exp_state});
   endtask
   // mid-run reset: toggled states and control must drop to off
   task automatic reset_clears();
      logic [31:0] rd;
      logic        err;
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      exp_state = 5'h00;
      check({27'h000_0000, stereo_alternation, comb_bypass, delay_bypass, comb_mute,
             delay_mute}, 32'h0000_0000);
      apb(1'b0, `TAD_STATE_OFS, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_0000);
      apb(1'b0, `TAD_CTRL_OFS, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_0000);
   endtask
   // verdict and end of run
   task automatic end_of_test();
      if (miscompares == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      end_of_test();
   end
   // main sequence
   initial begin
      logic [31:0] rd;
      logic        err;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      check({23'h00_0000, delay_mute, comb_mute, delay_bypass, comb_bypass, stereo_alternation,
             delay_freeze, delay_reverse, comb_clear, delay_clear}, 32'h0000_0000);
      apb(1'b0, `TAD_CTRL_OFS, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_0000);
      toggle_op(4'h0, 2'b00, 5'h01, 1'b0);
      toggle_op(4'h0, 2'b00, 5'h01, 1'b1);
      toggle_op(4'h1, 2'b00, 5'h02, 1'b0);
      toggle_op(4'h2, 2'b00, 5'h03, 1'b1);
      toggle_op(4'h2, 2'b01, 5'h00, 1'b0);
      toggle_op(4'h2, 2'b10, 5'h03, 1'b0);
      toggle_op(4'h3, 2'b00, 5'h04, 1'b0);
      toggle_op(4'h4, 2'b00, 5'h08, 1'b1);
      toggle_op(4'h5, 2'b00, 5'h0C, 1'b0);
      toggle_op(4'h5, 2'b10, 5'h00, 1'b1);
      toggle_op(4'h5, 2'b01, 5'h0C, 1'b0);
      toggle_op(4'h6, 2'b00, 5'h10, 1'b0);
      toggle_op(4'hA, 2'b00, 5'h00, 1'b0);
      toggle_op(4'h9, 2'b00, 5'h00, 1'b1);
      gated(4'h7, 1'b1);
      gated(4'h8, 1'b0);
      check(comb_clears, 32'h0000_0001);
      check(delay_clears, 32'h0000_0001);
      bad_access();
      reset_clears();
      end_of_test();
   end
endmodule // testbench
